// File: design/pos_pkg.sv
// Purpose: shared constants for the pwm output conditioning stage
// Assumes: one module clock, pins indexed a=0 .. f=5
// Notes:   high-side pins sit at even indices, low-side pins at odd ones
package pos_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int POS_DT_W    = 6;   // dead-time field width
	localparam int POS_MODE_W  = 3;   // output mode select width
	localparam int POS_SRC_W   = 8;   // shutdown source select width
	localparam int POS_PINS    = 6;   // output pins a .. f
	localparam int POS_STATE_W = 2;   // shutdown pin state field width

	// ----------------------------------------
	// output mode codes
	// ----------------------------------------
	localparam logic [POS_MODE_W-1:0] POS_MODE_HALF_BRIDGE = 3'h2;
	localparam logic [POS_MODE_W-1:0] POS_MODE_BDC_REVERSE = 3'h4;
	localparam logic [POS_MODE_W-1:0] POS_MODE_BDC_FORWARD = 3'h5;
	localparam logic [POS_MODE_W-1:0] POS_MODE_SCAN        = 3'h6;
	localparam logic [POS_MODE_W-1:0] POS_MODE_PP_DEFAULT  = 3'h3;

	// ----------------------------------------
	// shutdown pin state field codes
	// ----------------------------------------
	localparam logic [POS_STATE_W-1:0] POS_SD_INACTIVE = 2'h0;  // drive inactive
	localparam logic [POS_STATE_W-1:0] POS_SD_ACTIVE   = 2'h1;  // drive active
	// codes 2 and 3 both release the pin (high impedance)

	// ----------------------------------------
	// pin indices and reset values
	// ----------------------------------------
	localparam int POS_PIN_A = 0;
	localparam int POS_PIN_B = 1;
	localparam int POS_PIN_C = 2;
	localparam int POS_PIN_D = 3;
	localparam int POS_PIN_E = 4;
	localparam int POS_PIN_F = 5;
	localparam logic [POS_DT_W-1:0] POS_DT_IDLE = 6'h00;
	localparam logic [POS_PINS-1:0] POS_PINS_OFF = 6'h00;

endpackage

// File: design/pos_output_stage.sv
// Purpose: dead-time, mode blanking, auto-shutdown and polarity for six pwm pins
// Assumes: all inputs synchronous to i_clk; compare signal and period sync come from outside
// Notes:   every output is registered, so pins follow shutdown by one clock and the compare signal by two
`timescale 1ns/10ps

// Summary of operation
// - derive true and complementary signals from input
// - delay only rising edges by dead-time count
// - zero duty: both inactive, then true low
// - full duty: both inactive, then true high
// - half-bridge: a true, b complement, polarity later
// - half-bridge pair copied to c/d, e/f per enable
// - brushed-dc blanks a..d on toggle, e/f released
// - push-pull blanks at period boundary, polarity after
// - scan mode bypasses dead-time delay
// - selected sources shut down low, software bit high
// - shutdown level-sensitive and acts without waiting
// - two fields set high/low side shutdown state
// - disabled pins ignore shutdown
// - software bit holds shutdown until cleared
// - flag set while shutdown in effect
// - manual clear ignored while any selected source or software bit active
// - auto restart clears flag at period start
// - still active at period start: skip period
// - gated shutdown takes effect at period boundary
// - gated resume automatic only with restart enabled
// - two bits invert high and low pin groups
// - polarity applied after dead-time and shutdown
// - half-bridge selected by mode code two
// - brushed-dc forward five, reverse four
// - direction toggle loads counter, pair waits expiry
module pos_output_stage #(
	parameter logic [pos_pkg::POS_MODE_W-1:0] PUSH_PULL_MODE = pos_pkg::POS_MODE_PP_DEFAULT
) (
	input  wire logic                               i_clk,
	input  wire logic                               i_sys_rst,
	input  wire logic                               i_module_enable,
	input  wire logic                               i_pwm_in,
	input  wire logic                               i_period_sync,
	input  wire logic [pos_pkg::POS_DT_W-1:0]       i_dead_time_count,
	input  wire logic [pos_pkg::POS_MODE_W-1:0]     i_output_mode_select,
	input  wire logic [pos_pkg::POS_PINS-1:0]       i_pin_enable_bits,
	input  wire logic [pos_pkg::POS_SRC_W-1:0]      i_shutdown_source_select,
	input  wire logic [pos_pkg::POS_SRC_W-1:0]      i_shutdown_sources,
	input  wire logic                               i_software_shutdown,
	input  wire logic [pos_pkg::POS_STATE_W-1:0]    i_high_side_shutdown_state,
	input  wire logic [pos_pkg::POS_STATE_W-1:0]    i_low_side_shutdown_state,
	input  wire logic                               i_auto_restart_enable,
	input  wire logic                               i_gated_shutdown_enable,
	input  wire logic                               i_high_side_invert,
	input  wire logic                               i_low_side_invert,
	input  wire logic                               i_event_flag_clear,
	output logic      [pos_pkg::POS_PINS-1:0]       o_pin_out,
	output logic      [pos_pkg::POS_PINS-1:0]       o_pin_oe,
	output logic                                    o_shutdown_event_flag
);
	import pos_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic                  pwm_prev_reg;     // last sampled compare signal
	logic                  en_prev_reg;      // enable one clock ago
	logic [POS_MODE_W-1:0] mode_prev_reg;    // mode one clock ago
	logic [POS_DT_W-1:0]   cnt_reg;          // dead-time countdown
	logic [POS_DT_W-1:0]   cnt_next;
	logic                  phase_reg;        // push-pull side select
	logic                  gated_req_reg;    // request latched at boundary
	logic                  flag_reg;         // shutdown event status
	logic                  flag_next;
	logic [POS_PINS-1:0]   base_val;         // mode output before shutdown
	logic [POS_PINS-1:0]   base_oe;
	logic [POS_PINS-1:0]   pin_out_next;
	logic [POS_PINS-1:0]   pin_oe_next;
	logic                  in_edge;          // compare signal changed
	logic                  dt_done;          // countdown at zero
	logic                  dt_true;          // delayed true signal
	logic                  dt_comp;          // delayed complement
	logic                  mode_hb;
	logic                  mode_bdc;
	logic                  mode_pp;
	logic                  mode_scan;
	logic                  dir_toggle;       // forward/reverse swap
	logic                  raw_req;          // any selected source asking
	logic                  shut_req;         // request after gating
	logic                  shut_any;         // outputs forced safe now

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	assign mode_hb   = (i_output_mode_select == POS_MODE_HALF_BRIDGE);
	assign mode_bdc  = (i_output_mode_select == POS_MODE_BDC_FORWARD) ||
	                   (i_output_mode_select == POS_MODE_BDC_REVERSE);
	assign mode_pp   = (i_output_mode_select == PUSH_PULL_MODE);
	assign mode_scan = (i_output_mode_select == POS_MODE_SCAN);
	assign in_edge   = (i_pwm_in != pwm_prev_reg);
	// toggle only counts when staying inside the brushed-dc pair of codes
	assign dir_toggle = mode_bdc && en_prev_reg &&
	                    ((mode_prev_reg == POS_MODE_BDC_FORWARD) || (mode_prev_reg == POS_MODE_BDC_REVERSE)) &&
	                    (mode_prev_reg != i_output_mode_select);

	// ----------------------------------------
	// input sampling
	// ----------------------------------------
	// the delayed copy feeds the dead-time stage, so the counter is
	// already loaded when the new level reaches the gating term
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pwm_prev_reg  <= 1'b0;
			en_prev_reg   <= 1'b0;
			mode_prev_reg <= POS_MODE_HALF_BRIDGE;
		end else begin
			pwm_prev_reg  <= i_pwm_in;
			en_prev_reg   <= i_module_enable;
			mode_prev_reg <= i_output_mode_select;
		end
	end

	// ----------------------------------------
	// dead-time counter
	// ----------------------------------------
	always_comb begin
		cnt_next = cnt_reg;
		if (!i_module_enable) begin
			cnt_next = POS_DT_IDLE;
		end else if (!en_prev_reg) begin
			cnt_next = i_dead_time_count;
		end else if (mode_bdc && dir_toggle) begin
			cnt_next = i_dead_time_count;
		end else if (mode_pp && i_period_sync) begin
			cnt_next = i_dead_time_count;
		end else if (!mode_bdc && in_edge) begin
			cnt_next = i_dead_time_count;
		end else if (cnt_reg != POS_DT_IDLE) begin
			cnt_next = cnt_reg - 6'h01;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cnt_reg <= POS_DT_IDLE;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// only rising edges wait; a falling edge drops the output at once
	// the first enabled cycle is blanked too: the counter only loads on that edge
	assign dt_done = (cnt_reg == POS_DT_IDLE) && en_prev_reg;
	assign dt_true = pwm_prev_reg && dt_done;
	assign dt_comp = !pwm_prev_reg && dt_done;

	// ----------------------------------------
	// push-pull phase
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			phase_reg <= 1'b0;
		end else if (!i_module_enable || !mode_pp) begin
			phase_reg <= 1'b0;
		end else if (i_period_sync) begin
			phase_reg <= !phase_reg;
		end
	end

	// ----------------------------------------
	// per-mode pin values, active high
	// ----------------------------------------
	always_comb begin
		base_val = POS_PINS_OFF;
		base_oe  = i_pin_enable_bits;
		if (mode_hb) begin
			// same pair on a/b, c/d, e/f; enables pick the pins
			base_val = {dt_comp, dt_true, dt_comp, dt_true, dt_comp, dt_true};
		end else if (mode_bdc) begin
			base_oe[POS_PIN_E] = 1'b0;
			base_oe[POS_PIN_F] = 1'b0;
			// blank in the toggle cycle itself, before the counter has loaded
			if (dt_done && !(dir_toggle && (i_dead_time_count != POS_DT_IDLE))) begin
				if (i_output_mode_select == POS_MODE_BDC_FORWARD) begin
					base_val[POS_PIN_A] = pwm_prev_reg;
					base_val[POS_PIN_D] = 1'b1;
				end else begin
					base_val[POS_PIN_C] = pwm_prev_reg;
					base_val[POS_PIN_B] = 1'b1;
				end
			end
		end else if (mode_pp) begin
			// blanked while the boundary countdown runs
			base_val = {!phase_reg, phase_reg, !phase_reg, phase_reg, !phase_reg, phase_reg} &
			           {POS_PINS{pwm_prev_reg && dt_done}};
		end else if (mode_scan) begin
			base_val = {POS_PINS{pwm_prev_reg}};
		end else begin
			// steering of other modes lives upstream
			base_val = {POS_PINS{pwm_prev_reg}};
		end
	end

	// ----------------------------------------
	// shutdown request
	// ----------------------------------------
	// sources are low-active, the software bit high-active
	assign raw_req  = (|(i_shutdown_source_select & ~i_shutdown_sources)) || i_software_shutdown;
	assign shut_req = i_gated_shutdown_enable ? gated_req_reg : raw_req;
	// flag or live request: no wait for the flag flop to catch up
	assign shut_any = flag_reg || shut_req;

	// gated request is sampled only at period boundaries
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			gated_req_reg <= 1'b0;
		end else if (!i_module_enable) begin
			gated_req_reg <= 1'b0;
		end else if (i_period_sync) begin
			gated_req_reg <= raw_req;
		end
	end

	// ----------------------------------------
	// shutdown event flag
	// ----------------------------------------
	// set beats manual and auto-restart clears in the same clock; disable beats set
	always_comb begin
		flag_next = flag_reg;
		if (!i_module_enable) begin
			flag_next = 1'b0;
		end else if (shut_req) begin
			flag_next = 1'b1;
		end else if (i_auto_restart_enable) begin
			if (i_period_sync && !raw_req) begin
				flag_next = 1'b0;
			end
		end else if (i_event_flag_clear && !raw_req) begin
			flag_next = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	// ----------------------------------------
	// shutdown state and polarity per pin
	// ----------------------------------------
	generate
		for (genvar p = 0; p < POS_PINS; p++) begin : g_pin
			logic [POS_STATE_W-1:0] sd_state;
			logic                   inv;
			logic                   val;
			logic                   oe;
			assign sd_state = (p % 2 == 0) ? i_high_side_shutdown_state : i_low_side_shutdown_state;
			assign inv      = (p % 2 == 0) ? i_high_side_invert : i_low_side_invert;
			// a pin without its enable is never touched by shutdown
			assign val = (shut_any && i_pin_enable_bits[p]) ? (sd_state == POS_SD_ACTIVE) : base_val[p];
			assign oe  = (shut_any && i_pin_enable_bits[p]) ?
			             ((sd_state == POS_SD_INACTIVE) || (sd_state == POS_SD_ACTIVE)) : base_oe[p];
			assign pin_out_next[p] = i_module_enable && (val ^ inv);
			assign pin_oe_next[p]  = i_module_enable && oe && i_pin_enable_bits[p];
		end
	endgenerate

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_pin_out             <= POS_PINS_OFF;
			o_pin_oe              <= POS_PINS_OFF;
			o_shutdown_event_flag <= 1'b0;
		end else begin
			o_pin_out             <= pin_out_next;
			o_pin_oe              <= pin_oe_next;
			o_shutdown_event_flag <= flag_next;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	a_dt_reload_edge: assert property (i_module_enable && en_prev_reg && mode_hb && in_edge
		|=> cnt_reg == $past(i_dead_time_count)) else $error("dead-time not reloaded on edge");
	a_dt_blank_both: assert property (i_module_enable && mode_hb && !shut_any && !dt_done
		&& (&i_pin_enable_bits[1:0])
		|=> o_pin_out[0] == $past(i_high_side_invert) && o_pin_out[1] == $past(i_low_side_invert))
		else $error("half-bridge pins not both inactive in dead time");
	a_hb_complement: assert property (i_module_enable && mode_hb && !shut_any && dt_done
		|=> (o_pin_out[0] ^ $past(i_high_side_invert)) != (o_pin_out[1] ^ $past(i_low_side_invert)))
		else $error("half-bridge pair not complementary");
	a_scan_bypass: assert property (i_module_enable && mode_scan && !shut_any && in_edge
		##1 (mode_scan && !shut_any && i_module_enable && !i_high_side_invert)
		|=> o_pin_out[0] == $past(pwm_prev_reg)) else $error("scan mode delayed");
	a_bdc_ef_released: assert property (mode_bdc && !shut_any |=> o_pin_oe[5:4] == 2'h0)
		else $error("brushed-dc drove e/f");
	a_sw_shutdown_flag: assert property (i_module_enable && i_software_shutdown && !i_gated_shutdown_enable
		|=> o_shutdown_event_flag) else $error("software shutdown not flagged");
	a_clear_blocked: assert property (i_module_enable && flag_reg && raw_req
		|=> flag_reg) else $error("flag cleared under active source");
	a_auto_restart: assert property (i_module_enable && flag_reg && i_auto_restart_enable && i_period_sync
		&& !raw_req && !shut_req |=> !flag_reg) else $error("auto restart missed period start");
	a_gated_defer: assert property (i_module_enable && i_gated_shutdown_enable && !gated_req_reg
		&& !i_period_sync && !flag_reg |=> !flag_reg) else $error("gated shutdown acted mid period");
	a_pin_off_ignored: assert property (!i_pin_enable_bits[0] |=> !o_pin_oe[0])
		else $error("disabled pin driven");
	a_shut_hiz: assert property (i_module_enable && shut_any && i_pin_enable_bits[0]
		&& i_high_side_shutdown_state[1] |=> !o_pin_oe[0]) else $error("hi-z shutdown state driven");
	a_bdc_toggle_blank: assert property (i_module_enable && dir_toggle && !shut_any && (i_dead_time_count != POS_DT_IDLE)
		|=> o_pin_out[3:0] == {$past(i_low_side_invert), $past(i_high_side_invert),
		                       $past(i_low_side_invert), $past(i_high_side_invert)})
		else $error("brushed-dc pins active on direction toggle");

	c_hb_dead_time: cover property (mode_hb && in_edge ##1 !dt_done [*2] ##1 dt_done);
	c_auto_restart: cover property (flag_reg && i_auto_restart_enable ##1 !flag_reg);
	c_gated_shut: cover property (i_gated_shutdown_enable && i_period_sync && raw_req ##1 flag_reg);
	c_bdc_toggle: cover property (dir_toggle && i_dead_time_count != POS_DT_IDLE);

endmodule

// File: dv/pos_switch_model.sv
// Purpose: behavioural model of the external power switches on the six pins
// Assumes: pins a..f indexed 0..5, level high means switch conducting
// Notes:   a released pin shows the inverse of its last level, never a clean value
`timescale 1ns/10ps

// ----------------------------------------
// switch model
// ----------------------------------------
module pos_switch_model (
	input  wire logic [pos_pkg::POS_PINS-1:0] i_pin_out,
	input  wire logic [pos_pkg::POS_PINS-1:0] i_pin_oe,
	input  wire logic                         i_clk,
	output logic      [pos_pkg::POS_PINS-1:0] o_level,
	output int                                o_overlap
);
	import pos_pkg::*;
	logic [POS_PINS-1:0] last_reg = '0;  // last level seen on each pin
	int                  overlap_cnt = 0;  // cycles with both a/b switches on
	assign o_overlap = overlap_cnt;

	// released pins drift away from their last level so stale values never pass
	always_comb begin
		o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & ~last_reg);
	end

	// count cycles where both switches of leg a/b conduct together
	always @(posedge i_clk) begin
		last_reg <= o_level;
		if (o_level[0] && o_level[1] && i_pin_oe[0] && i_pin_oe[1]) begin
			overlap_cnt <= overlap_cnt + 1;
		end
	end
endmodule

// File: dv/testbench.sv
// Purpose: self-checking bench for the pwm output conditioning stage
// Assumes: inputs change 1 ns after the rising edge, sampled there too
// Notes:   expectations come from mode codes and dead-time values set here
`timescale 1ns/10ps
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, s); end end

module testbench;
	import pos_pkg::*;
	// ----------------------------------------
	// stimulus and observation
	// ----------------------------------------
	logic i_clk = 0, i_sys_rst = 1, en = 0, pwm = 0, sync = 0, sw = 0;
	logic are = 0, gse = 0, hinv = 0, linv = 0, fclr = 0;
	logic [POS_DT_W-1:0]    dt = '0;         // dead-time cycles
	logic [POS_MODE_W-1:0]  mode = POS_MODE_HALF_BRIDGE;
	logic [POS_PINS-1:0]    pen = 6'h3F;     // pin enables
	logic [POS_SRC_W-1:0]   ssel = '0, src = 8'hFF;  // sources idle high
	logic [POS_STATE_W-1:0] hst = '0, lst = '0;
	logic [POS_PINS-1:0]    pin, oe, lvl;
	logic                   flg;
	int                     ovl, errors = 0, checks = 0;

	pos_output_stage pos_output_stage_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_module_enable(en),
		.i_pwm_in(pwm), .i_period_sync(sync), .i_dead_time_count(dt), .i_output_mode_select(mode),
		.i_pin_enable_bits(pen), .i_shutdown_source_select(ssel), .i_shutdown_sources(src),
		.i_software_shutdown(sw), .i_high_side_shutdown_state(hst), .i_low_side_shutdown_state(lst),
		.i_auto_restart_enable(are), .i_gated_shutdown_enable(gse), .i_high_side_invert(hinv),
		.i_low_side_invert(linv), .i_event_flag_clear(fclr), .o_pin_out(pin), .o_pin_oe(oe),
		.o_shutdown_event_flag(flg));
	pos_switch_model pos_switch_model_inst (.i_pin_out(pin), .i_pin_oe(oe), .i_clk(i_clk),
		.o_level(lvl), .o_overlap(ovl));

	initial begin
		forever #20 i_clk = ~i_clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic clr_pulse;  // software clear of the status flag
		fclr = 1; cyc(1); fclr = 0; cyc(1);
	endtask
	task automatic sync_pulse;  // one period boundary
		sync = 1; cyc(1); sync = 0; cyc(3);
	endtask

	// edge gap between turn-off of one leg and turn-on of the other
	task automatic t_dead(input logic [POS_DT_W-1:0] d);
		int ta, tb, o0;
		o0 = ovl; dt = d; mode = POS_MODE_HALF_BRIDGE;
		for (int l = 1; l >= 0; l--) begin
			cyc(70); pwm = l[0]; ta = 0; tb = 0;
			for (int i = 1; i < 80; i++) begin
				cyc(1);
				if (tb == 0 && pin[l] !== 1'b1) tb = i;
				if (ta == 0 && pin[1-l] === 1'b1) ta = i;
			end
			`CHK("dead_gap", int'(d), ta - tb)
			`CHK("leg_seen", 1'b1, ta > 0)
		end
		`CHK("overlap", o0, ovl)
	endtask

	// steady 0% and 100% duty straight after enable
	task automatic t_duty;
		for (int l = 0; l < 2; l++) begin
			en = 0; pwm = l[0]; dt = 6'h08; cyc(2); en = 1; cyc(3);
			`CHK("duty_blank", 4'b0011, {pin[1:0], oe[1:0]})
			cyc(12);
			`CHK("duty_hold", {~l[0], l[0]}, pin[1:0])
		end
	endtask

	// only pair c/d enabled in half bridge
	task automatic t_copy;
		pen = 6'b001100; pwm = 1; dt = '0; cyc(6);
		`CHK("copy_oe", 6'b001100, oe)
		`CHK("copy_cd", 2'b01, pin[3:2])
		`CHK("copy_lvl", 2'b01, lvl[3:2])
		pen = 6'h3F;
	endtask

	// forward, then direction toggle with blanking
	task automatic t_bdc;
		mode = POS_MODE_BDC_FORWARD; pwm = 1; dt = 6'h06; cyc(10);
		`CHK("fwd_pins", 4'b1001, pin[3:0])
		`CHK("ef_oe", 2'b00, oe[5:4])
		mode = POS_MODE_BDC_REVERSE; cyc(1);
		`CHK("dir_blank", 4'b0000, pin[3:0])
		cyc(10);
		`CHK("rev_pins", 4'b0110, pin[3:0])
	endtask

	// scan mode ignores a long dead time
	task automatic t_scan;
		int t;
		mode = POS_MODE_SCAN; pen = 6'h01; dt = 6'h28; pwm = 0; cyc(60); pwm = 1; t = 0;
		for (int i = 1; i < 8; i++) begin
			cyc(1);
			if (t == 0 && pin[0] === 1'b1) t = i;
		end
		`CHK("scan_fast", 2, t)
		mode = 3'h7; hinv = 1; cyc(3);
		`CHK("pol_any_mode", 1'b0, pin[0])
		hinv = 0; pen = 6'h3F;
	endtask

	// push-pull legs alternate period by period
	task automatic t_pp;
		logic [1:0] p1;
		mode = POS_MODE_PP_DEFAULT; dt = '0; pwm = 1; sync_pulse(); cyc(3); p1 = pin[1:0];
		sync_pulse(); cyc(3);
		`CHK("pp_alt", ~p1, pin[1:0])
		`CHK("pp_one", 1'b1, p1[0] ^ p1[1])
	endtask

	// safe states, polarity after shutdown, manual restart
	task automatic t_sd;
		mode = POS_MODE_HALF_BRIDGE; dt = '0; pwm = 1; are = 0; pen = 6'h1F; ssel = 8'h08;
		src = 8'hFE; cyc(4);
		`CHK("unsel_src", 1'b0, flg)
		for (int k = 0; k < 3; k++) begin
			hst = k[1:0]; lst = k[1:0]; hinv = k[0]; src = 8'hF7; cyc(2);
			`CHK("sd_flag", 1'b1, flg)
			`CHK("sd_oe", (k == 2) ? 6'h00 : 6'h1F, oe)
			if (k < 2) `CHK("sd_ab", {k[0], k[0] ^ hinv}, pin[1:0])
			clr_pulse(); cyc(1);
			`CHK("clr_refused", 1'b1, flg)
			src = 8'hFF; cyc(4);
			`CHK("no_self_clear", 1'b1, flg)
			clr_pulse(); cyc(2);
			`CHK("resumed", {1'b0, ~hinv}, pin[1:0])
		end
		hinv = 0; pen = 6'h3F;
	endtask

	// automatic restart waits for a clean period start
	task automatic t_auto;
		are = 1; src = 8'hF7; cyc(3); sync_pulse();
		`CHK("skip_period", 1'b1, flg)
		src = 8'hFF; cyc(3);
		`CHK("wait_sync", 1'b1, flg)
		sync_pulse();
		`CHK("auto_clear", 1'b0, flg)
		`CHK("auto_pin", 1'b1, pin[0])
	endtask

	// software shutdown holds until the bit drops
	task automatic t_sw;
		are = 0; ssel = '0; sw = 1; cyc(6);
		`CHK("sw_flag", 1'b1, flg)
		clr_pulse(); cyc(1);
		`CHK("sw_hold", 1'b1, flg)
		sw = 0; clr_pulse(); cyc(1);
		`CHK("sw_clear", 1'b0, flg)
	endtask

	// gated shutdown defers to period boundaries
	task automatic t_gate;
		gse = 1; ssel = 8'h08;
		for (int r = 1; r >= 0; r--) begin
			are = r[0]; src = 8'hF7; cyc(4);
			`CHK("gate_defer", 2'b01, {flg, pin[0]})
			sync_pulse();
			`CHK("gate_take", 1'b1, flg)
			src = 8'hFF; sync_pulse(); sync_pulse();
			`CHK("gate_resume", ~r[0], flg)
			clr_pulse(); cyc(1);
			`CHK("gate_clear", 1'b0, flg)
		end
		gse = 0;
	endtask

	// ----------------------------------------
	// verdict and run control
	// ----------------------------------------
	task automatic finish_test;
		if (errors == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#(40 * 20000);
		errors++;
		finish_test();
	end

	initial begin
		cyc(12); i_sys_rst = 0; cyc(1); en = 1; cyc(2);
		t_dead(6'h00); t_dead(6'h05); t_dead(6'h3F);
		t_duty(); t_copy(); t_bdc(); t_scan(); t_pp();
		t_sd(); t_auto(); t_sw(); t_gate();
		finish_test();
	end
endmodule
